// ==== tbt_defs.vh ====
// Register offsets, alias codes, field positions, write masks and reset values
`ifndef TBT_DEFS_VH
`define TBT_DEFS_VH

`define TBT_CON_EVEN     12'h000
`define TBT_CNT_EVEN     12'h010
`define TBT_PER_EVEN     12'h020
`define TBT_CON_ODD      12'h040
`define TBT_CNT_ODD      12'h050
`define TBT_PER_ODD      12'h060
`define TBT_IRQ_STAT     12'h080
`define TBT_IRQ_MASK     12'h090
`define TBT_ALIAS_CLR    2'h1
`define TBT_ALIAS_SET    2'h2
`define TBT_ALIAS_INV    2'h3
`define TBT_BIT_ON       15
`define TBT_BIT_IDLE_STOP     13
`define TBT_BIT_GATE     7
`define TBT_PS_HI        6
`define TBT_PS_LO        4
`define TBT_BIT_PAIR     3
`define TBT_BIT_CSRC     1
`define TBT_CON_WMASK_E  32'h0000a0fa
`define TBT_CON_WMASK_O  32'h0000a0f2
`define TBT_CON_RST      32'h00000000
`define TBT_CNT_RST      16'h0000
`define TBT_PER_RST      16'hffff

`endif

// ==== tbt_prescale.v ====
// Prescaler producing one-cycle count ticks from a base tick stream
`timescale 1ns/10ps
`default_nettype none

module tbt_prescale (
	input  wire       pclk,     // Peripheral clock
	input  wire       presetn,  // Async reset, active low
	input  wire       ce,       // Clock enable
	input  wire       clr,      // Restart the divider
	input  wire       tick_in,  // Base tick
	input  wire [2:0] sel,      // Division code
	output reg        tick_out  // Prescaled tick
);

	reg  [7:0] div_r;    // Base tick counter
	wire [7:0] last;     // Terminal count

	// Divide by 1,2,4,8,16,32,64,256
	function [7:0] div_last;
		input [2:0] s;
		begin
			case (s)
			3'h7:    div_last = 8'hff;
			default: div_last = (8'h01 << s) - 8'h01;
			endcase
		end
	endfunction

	assign last = div_last(sel);

	// Counter wraps at the terminal count and emits a tick
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			div_r    <= 8'h00;
			tick_out <= 1'b0;
		end else if (ce) begin
			tick_out <= 1'b0;
			if (clr) begin
				div_r <= 8'h00;
			end else if (tick_in) begin
				if (div_r >= last) begin
					div_r    <= 8'h00;
					tick_out <= 1'b1;
				end else begin
					div_r <= div_r + 8'h01;
				end
			end
		end
	end

endmodule

`default_nettype wire

// ==== tbt_timer.v ====
// Type B timer pair with control registers, APB slave and interrupt
`timescale 1ns/10ps
`default_nettype none
`include "tbt_defs.vh"

// Register map, one aligned 32-bit word per register:
//   even control 0x000, even count 0x010, even period 0x020
//   odd control 0x040, odd count 0x050, odd period 0x060
//   status 0x080, interrupt mask 0x090
// Each word but the status also answers at +0x4 (clear), +0x8 (set), +0xc (invert),
// acting only on the bits written as one; status clears its one bits at every alias.
//
// Bus timing: a setup cycle is answered in the very next cycle with
// pready high for one cycle; a write lands at the edge that ends the
// access cycle, read data are captured from the setup cycle.
// Unmapped words answer with pslverr, ignore writes and read zero.
//
// Counting: the base tick is every peripheral clock, or a rising edge
// of the count clock pin seen by pclk. The prescaler divides it and
// restarts whenever its timer stops, so a run starts on a fresh period.
// A counter equal to its period wraps to zero at the next count and
// raises its status bit; counting continues after the wrap.
//
// Gated mode counts only while the gate pin is high and raises the
// status bit when the gate falls; the external clock disables it.
//
// Pair mode joins the odd counter above the even one. All controls
// then come from the even register, except that the odd idle stop
// still halts the pair in Idle; software must clear it there.
//
// Status bits are sticky and cleared by writing ones; an event in the
// same cycle wins. irq is registered from the masked status.
//
// Hazards: the pins are taken as synchronous, with no synchroniser;
// a low clock enable freezes the bus answer as well as the timers.

module tbt_timer #(
	parameter CW = 16          // Width of one counter
) (
	input  wire        pclk,      // Peripheral clock
	input  wire        presetn,   // Async reset, active low
	input  wire        ce,        // Clock enable, freezes all state
	input  wire        psel,      // APB select
	input  wire        penable,   // APB enable
	input  wire        pwrite,    // APB write
	input  wire [11:0] paddr,     // APB byte address
	input  wire [31:0] pwdata,    // APB write data
	output reg  [31:0] prdata,    // APB read data
	output reg         pready,    // APB ready
	output reg         pslverr,   // APB error, unmapped address
	input  wire        idle_mode, // Device in Idle mode
	input  wire        ext_clk_e, // Even ext_count_clock_pin, synchronous
	input  wire        ext_clk_o, // Odd ext_count_clock_pin, synchronous
	input  wire        gate_e,    // Even gate input, synchronous
	input  wire        gate_o,    // Odd gate input, synchronous
	output reg         irq        // Level interrupt
);

	// Control and data registers
	reg  [31:0]   con_e_r;     // Even timer_control
	reg  [31:0]   con_o_r;     // Odd timer_control
	reg  [CW-1:0] cnt_e_r;     // Even counter
	reg  [CW-1:0] cnt_o_r;     // Odd counter
	reg  [CW-1:0] per_e_r;     // Even period
	reg  [CW-1:0] per_o_r;     // Odd period
	reg  [1:0]    stat_r;      // Sticky events, bit0 even, bit1 odd
	reg  [1:0]    mask_r;      // Interrupt mask
	reg           ext_e_d_r;   // Previous even ext pin
	reg           ext_o_d_r;   // Previous odd ext pin
	reg           gate_e_d_r;  // Previous even gate
	reg           gate_o_d_r;  // Previous odd gate

	// Effective controls
	wire          pair;        // 32-bit pair mode
	wire          run_e;       // Even timer counting allowed
	wire          run_o;       // Odd timer counting allowed
	wire          base_e;      // Even base tick
	wire          base_o;      // Odd base tick
	wire          ptick_e;     // Even prescaled tick
	wire          ptick_o;     // Odd prescaled tick
	wire          gmode_e;     // Even gated mode
	wire          gmode_o;     // Odd gated mode
	wire          inc_e;       // Even increment
	wire          inc_o;       // Odd increment
	wire          gfall_e;     // Even gate falling edge
	wire          gfall_o;     // Odd gate falling edge
	wire [2*CW-1:0] cnt32;     // Joined counter
	wire [2*CW-1:0] per32;     // Joined period

	// Bus decode
	wire          acc;         // Access phase
	wire          wr;          // Write taking effect
	wire [1:0]    alias_sel;   // Alias of the word
	wire [11:0]   base_addr;   // Address without alias bits
	reg           hit;         // Mapped address
	reg  [31:0]   rd_val;      // Read value

	// Write merge and event bookkeeping
	wire [31:0]   wr_data;     // Addressed word after the alias merge
	reg  [1:0]    ev_set;      // Events raised this cycle
	wire [1:0]    ev_clr;      // Status bits cleared by software
	wire [1:0]    stat_nxt;    // Status after clears and events

	// Merge a write through the alias selector
	function [31:0] alias_wr;
		input [31:0] old;
		input [31:0] wd;
		input [1:0]  a;
		begin
			case (a)
			`TBT_ALIAS_CLR: alias_wr = old & ~wd;
			`TBT_ALIAS_SET: alias_wr = old | wd;
			`TBT_ALIAS_INV: alias_wr = old ^ wd;
			default:        alias_wr = wd;
			endcase
		end
	endfunction

	// Control register read view, gate hidden under external clock
	function [31:0] con_view;
		input [31:0] c;
		begin
			con_view = c;
			if (c[`TBT_BIT_CSRC])
				con_view[`TBT_BIT_GATE] = 1'b0;
		end
	endfunction

	// Access phase, write strobe and alias split of the address
	assign acc       = psel & penable;
	assign wr        = acc & pwrite & ce & hit;
	assign alias_sel = paddr[3:2];
	assign base_addr = {paddr[11:4], 4'h0};
	// Count, period and mask words merge through the alias here;
	// the control words use their stored value so a hidden gate bit
	// survives a set, clear or invert write
	assign wr_data   = alias_wr(rd_val, pwdata, alias_sel);

	// Pair mode lives only in the even register
	assign pair = con_e_r[`TBT_BIT_PAIR];

	// Enable and idle stop; in pair mode the odd idle stop joins in,
	// since the even timer alone drives the joined counter
	assign run_e = con_e_r[`TBT_BIT_ON] &
		~(idle_mode & con_e_r[`TBT_BIT_IDLE_STOP]) &
		~(pair & idle_mode & con_o_r[`TBT_BIT_IDLE_STOP]);
	// In pair mode the odd timer follows the even one
	assign run_o = pair ? run_e
		: (con_o_r[`TBT_BIT_ON] &
		~(idle_mode & con_o_r[`TBT_BIT_IDLE_STOP]));

	// Clock source: external rising edge or every peripheral clock
	assign base_e = con_e_r[`TBT_BIT_CSRC] ? (ext_clk_e & ~ext_e_d_r)
		: 1'b1;
	assign base_o = con_o_r[`TBT_BIT_CSRC] ? (ext_clk_o & ~ext_o_d_r)
		: 1'b1;

	// Gated mode only with internal clock
	assign gmode_e = con_e_r[`TBT_BIT_GATE] &
		~con_e_r[`TBT_BIT_CSRC];
	assign gmode_o = con_o_r[`TBT_BIT_GATE] &
		~con_o_r[`TBT_BIT_CSRC];

	// Increment on a prescaled tick unless the gate holds it off
	assign inc_e = run_e & ptick_e & (~gmode_e | gate_e);
	assign inc_o = run_o & ptick_o & (~gmode_o | gate_o);
	// Gate release ends an accumulation and counts as an event
	assign gfall_e = gmode_e & run_e & gate_e_d_r & ~gate_e;
	assign gfall_o = gmode_o & run_o & gate_o_d_r & ~gate_o;

	// Joined count and period, odd half on top
	assign cnt32 = {cnt_o_r, cnt_e_r};
	assign per32 = {per_o_r, per_e_r};

	// Even prescaler, drives the pair in 32-bit mode
	tbt_prescale u_ps_e (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.clr      (~run_e),
		.tick_in  (base_e & run_e),
		.sel      (con_e_r[`TBT_PS_HI:`TBT_PS_LO]),
		.tick_out (ptick_e)
	);

	// Odd prescaler, idle in 32-bit mode
	tbt_prescale u_ps_o (
		.pclk     (pclk),
		.presetn  (presetn),
		.ce       (ce),
		.clr      (~run_o | pair),
		.tick_in  (base_o & run_o),
		.sel      (con_o_r[`TBT_PS_HI:`TBT_PS_LO]),
		.tick_out (ptick_o)
	);

	// Address decode and read mux
	always @* begin
		hit    = 1'b1;
		rd_val = 32'h00000000;
		case (base_addr)
		`TBT_CON_EVEN: rd_val = con_view(con_e_r);
		`TBT_CON_ODD:  rd_val = con_view(con_o_r);
		`TBT_CNT_EVEN: rd_val = {{(32-CW){1'b0}}, cnt_e_r};
		`TBT_CNT_ODD:  rd_val = {{(32-CW){1'b0}}, cnt_o_r};
		`TBT_PER_EVEN: rd_val = {{(32-CW){1'b0}}, per_e_r};
		`TBT_PER_ODD:  rd_val = {{(32-CW){1'b0}}, per_o_r};
		`TBT_IRQ_STAT: rd_val = {30'h00000000, stat_r};
		`TBT_IRQ_MASK: rd_val = {30'h00000000, mask_r};
		default:       hit = 1'b0;
		endcase
	end

	// APB answer: ready in the access cycle, registered one cycle later
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
		end else if (ce) begin
			// A setup cycle is answered in the access cycle that follows
			pready  <= psel & ~penable;
			pslverr <= psel & ~penable & ~hit;
			// Read data are taken from the setup cycle and then held
			if (psel & ~penable & ~pwrite)
				prdata <= rd_val;
		end
	end

	// Control, period and mask registers; control words keep writable bits only
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			con_e_r <= `TBT_CON_RST;
			con_o_r <= `TBT_CON_RST;
			per_e_r <= `TBT_PER_RST;
			per_o_r <= `TBT_PER_RST;
			mask_r  <= 2'h0;
		end else if (ce && wr && pready) begin
			case (base_addr)
			`TBT_CON_EVEN: con_e_r <= alias_wr(con_e_r, pwdata,
				alias_sel) & `TBT_CON_WMASK_E;
			`TBT_CON_ODD:  con_o_r <= alias_wr(con_o_r, pwdata,
				alias_sel) & `TBT_CON_WMASK_O;
			`TBT_PER_EVEN: per_e_r <= wr_data[CW-1:0];
			`TBT_PER_ODD:  per_o_r <= wr_data[CW-1:0];
			`TBT_IRQ_MASK: mask_r  <= wr_data[1:0];
			default: ;
			endcase
		end
	end

	// Edge history of the pins
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ext_e_d_r  <= 1'b0;
			ext_o_d_r  <= 1'b0;
			gate_e_d_r <= 1'b0;
			gate_o_d_r <= 1'b0;
		end else if (ce) begin
			ext_e_d_r  <= ext_clk_e;
			ext_o_d_r  <= ext_clk_o;
			gate_e_d_r <= gate_e;
			gate_o_d_r <= gate_o;
		end
	end

	// Counters; software write wins over counting in the same cycle
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_e_r <= `TBT_CNT_RST;
			cnt_o_r <= `TBT_CNT_RST;
		end else if (ce) begin
			// Pair mode: one joined count on the even controls
			if (pair) begin
				if (inc_e) begin
					if (cnt32 == per32)
						{cnt_o_r, cnt_e_r} <= {2*CW{1'b0}};
					else
						{cnt_o_r, cnt_e_r} <= cnt32 + 1'b1;
				end
			end else begin
				// Two independent 16-bit counters
				if (inc_e)
					cnt_e_r <= (cnt_e_r == per_e_r) ? {CW{1'b0}}
						: cnt_e_r + 1'b1;
				if (inc_o)
					cnt_o_r <= (cnt_o_r == per_o_r) ? {CW{1'b0}}
						: cnt_o_r + 1'b1;
			end
			// A software write lands after the count and so wins
			if (wr && pready && base_addr == `TBT_CNT_EVEN)
				cnt_e_r <= wr_data[CW-1:0];
			if (wr && pready && base_addr == `TBT_CNT_ODD)
				cnt_o_r <= wr_data[CW-1:0];
		end
	end

	// Events of this cycle: terminal count reached or gate released
	always @* begin
		ev_set = 2'h0;
		if (pair) begin
			// The pair reports on the even bit only
			ev_set[0] = (inc_e & (cnt32 == per32)) | gfall_e;
		end else begin
			ev_set[0] = (inc_e & (cnt_e_r == per_e_r)) | gfall_e;
			ev_set[1] = (inc_o & (cnt_o_r == per_o_r)) | gfall_o;
		end
	end

	// Software clears the status bits it writes as one
	assign ev_clr = (wr && pready && base_addr == `TBT_IRQ_STAT) ?
		pwdata[1:0] : 2'h0;

	// A new event wins over a write-one clear in the same cycle
	assign stat_nxt = (stat_r & ~ev_clr) | ev_set;

	// Sticky status and the level interrupt
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			stat_r <= 2'h0;
			irq    <= 1'b0;
		end else if (ce) begin
			stat_r <= stat_nxt;
			irq    <= |(stat_nxt & mask_r);
		end
	end

endmodule

`default_nettype wire

// ==== tbt_pins.sv ====
// Count clock and gate pin source facing the timer
`timescale 1ns/10ps
`default_nettype none
module tbt_pins (
	input  wire logic pclk,     // Clock
	input  wire logic presetn,  // Reset, low
	input  wire logic run,      // Let clock run
	input  wire logic gate_lvl, // Gate level asked
	output var  logic ext_clk,  // Count clock pin
	output var  logic gate      // Gate pin
);
	logic [5:0] ph_r; // Phase count, one rise per four cycles
	// Clock rests low outside bursts
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			ph_r <= 6'h00;
		else if (run)
			ph_r <= ph_r + 6'h01;
		else
			ph_r <= 6'h00;
	end
	assign ext_clk = ph_r[1];
	assign gate = gate_lvl;
endmodule
`default_nettype wire

// ==== tbt_chk_chk.sv ====
// Bus answer and control readback checks
`timescale 1ns/10ps
`default_nettype none
module tbt_chk (
	input wire logic        pclk,    // Clock
	input wire logic        presetn, // Reset, low
	input wire logic        ce,      // Clock enable
	input wire logic        psel,    // Select
	input wire logic        penable, // Enable
	input wire logic        pwrite,  // Write
	input wire logic [11:0] paddr,   // Address
	input wire logic [31:0] prdata,  // Read data
	input wire logic        pready,  // Ready
	input wire logic        pslverr  // Error
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [7:0] blk; // Register block
	logic       rdq; // Read answer now
	logic       mapd; // Block exists
	assign blk = paddr[11:4];
	assign rdq = pready && !pwrite;
	assign mapd = blk inside {0, 1, 2, 4, 5, 6, 8, 9};
	sequence s_setup; psel && !penable && ce; endsequence
	sequence s_ans; psel && penable && pready; endsequence
	property p_ans; s_setup |=> s_ans; endproperty
	property p_one; $rose(pready) |=> !pready; endproperty
	property p_err;
		pready && !mapd |-> pslverr && (pwrite || prdata == 32'h0);
	endproperty
	property p_ok; pready && mapd |-> !pslverr; endproperty
	property p_cone; rdq && blk == 8'h00 |-> !(prdata & 32'hffff5f05);
	endproperty
	property p_cono; rdq && blk == 8'h04 |-> !(prdata & 32'hffff5f0d);
	endproperty
	property p_gate; rdq && (blk == 8'h00 || blk == 8'h04) && prdata[1]
		|-> !prdata[7]; endproperty
	property p_cnt; rdq && blk inside {1, 2, 5, 6} |-> prdata[31:16] == 0;
	endproperty
	a_ans: assert property (p_ans) else $error("no answer");
	a_one: assert property (p_one) else $error("ready too long");
	a_err: assert property (p_err) else $error("no error");
	a_ok: assert property (p_ok) else $error("false error");
	a_cone: assert property (p_cone) else $error("even bits");
	a_cono: assert property (p_cono) else $error("odd bits");
	a_gate: assert property (p_gate) else $error("gate bit");
	a_cnt: assert property (p_cnt) else $error("count width");
endmodule
bind tbt_timer tbt_chk tbt_chk_inst (.pclk(pclk), .presetn(presetn),
	.ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr));
`default_nettype wire

// ==== tb.sv ====
// Bench for the timer pair over the bus
`timescale 1ns/10ps
`default_nettype none
`include "tbt_defs.vh"
module tb;
	logic        pclk = 1'h0, presetn = 1'h0;  // Clock, reset
	logic        psel = 1'h0, penable = 1'h0;  // Bus phase
	logic        pwrite = 1'h0, idle = 1'h0;   // Direction, idle
	logic        run = 1'h0, glv = 1'h0;       // Pin requests
	logic        ce = 1'h1;                    // Clock enable
	logic [11:0] paddr = 12'h000;              // Address
	logic [31:0] pwdata = 32'h0, prdata, v;    // Data
	logic        pready, pslverr, irq, eq;     // Answers
	logic        xclk, gate;                   // Pins
	int          error_cnt = 0, n_compared = 0; // Counts
	int          n, k;                         // Loops
	always #5 pclk = ~pclk;
	tbt_timer tbt_timer_inst (.pclk(pclk), .presetn(presetn), .ce(ce),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .idle_mode(idle), .ext_clk_e(xclk),
		.ext_clk_o(xclk), .gate_e(gate), .gate_o(gate), .irq(irq));
	tbt_pins tbt_pins_inst (.pclk(pclk), .presetn(presetn), .run(run),
		.gate_lvl(glv), .ext_clk(xclk), .gate(gate));
	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask
	// One bus transfer, held until ready, then one idle cycle
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int i;
		i = 0;
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk) penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1 && i < 16) begin
			@(posedge pclk);
			i++;
		end
		if (pready !== 1'h1) begin
			error_cnt++;
			summarize();
		end
		v = prdata;
		eq = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		@(posedge pclk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'h1, a, d);
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		apb(1'h0, a, 32'h0);
		chk($sformatf("reg %h", a), v, e);
	endtask
	task automatic cyc(input int c);
		repeat (c) @(posedge pclk);
	endtask
	function automatic int dv(input int c);
		return (c == 7) ? 256 : (1 << c);
	endfunction
	initial begin
		cyc(8);
		presetn <= 1'h1;
		@(posedge pclk);
		rd(`TBT_CON_EVEN, 32'h0);
		rd(`TBT_PER_EVEN, 32'hffff);
		rd(`TBT_CNT_ODD, 32'h0);
		rd(12'h0a0, 32'h0);
		chk("slverr", eq, 32'h1);
		wr(`TBT_CON_EVEN, 32'hffffffff);
		rd(`TBT_CON_EVEN, 32'h0000a07a);
		wr(`TBT_CON_ODD, 32'hffffffff);
		rd(`TBT_CON_ODD, 32'h0000a072);
		wr(`TBT_CON_EVEN, 32'h30);
		wr(`TBT_CON_EVEN | 12'h8, 32'h40);
		rd(`TBT_CON_EVEN, 32'h70);
		wr(`TBT_CON_EVEN | 12'h4, 32'h10);
		rd(`TBT_CON_EVEN, 32'h60);
		wr(`TBT_CON_EVEN | 12'hc, 32'h70);
		rd(`TBT_CON_EVEN, 32'h10);
		wr(`TBT_CON_ODD, 32'hf2);
		$display("registers done");
		wr(`TBT_PER_EVEN, 32'h1);
		wr(`TBT_IRQ_MASK, 32'h1);
		for (k = 0; k < 8; k++) begin
			wr(`TBT_CNT_EVEN, 32'h0);
			wr(`TBT_CON_EVEN, 32'h8000 | (k << 4));
			n = 0;
			while (irq !== 1'h1 && n < 600) begin
				@(posedge pclk);
				n++;
			end
			if (irq !== 1'h1) begin
				error_cnt++;
				summarize();
			end
			chk("period", n >= 2 * dv(k) - 2 && n <= 2 * dv(k) + 4, 1);
			wr(`TBT_CON_EVEN, 32'h0);
			wr(`TBT_IRQ_MASK, 32'h0);
			cyc(1);
			chk("masked", irq, 32'h0);
			rd(`TBT_IRQ_STAT, 32'h1);
			wr(`TBT_IRQ_STAT, 32'h1);
			rd(`TBT_IRQ_STAT, 32'h0);
			wr(`TBT_IRQ_MASK, 32'h1);
		end
		$display("prescale done");
		wr(`TBT_PER_EVEN, 32'hffff);
		wr(`TBT_CNT_EVEN, 32'h5);
		cyc(20);
		rd(`TBT_CNT_EVEN, 32'h5);
		idle <= 1'h1;
		wr(`TBT_CON_EVEN, 32'ha000);
		cyc(20);
		rd(`TBT_CNT_EVEN, 32'h5);
		wr(`TBT_CON_EVEN, 32'h8000);
		cyc(20);
		wr(`TBT_CON_EVEN, 32'h0);
		apb(1'h0, `TBT_CNT_EVEN, 32'h0);
		chk("idle run", v > 32'h14, 1);
		idle <= 1'h0;
		$display("idle done");
		wr(`TBT_CNT_EVEN, 32'h0);
		wr(`TBT_CON_EVEN, 32'h8082);
		rd(`TBT_CON_EVEN, 32'h8002);
		run <= 1'h1;
		cyc(40);
		run <= 1'h0;
		cyc(4);
		rd(`TBT_CNT_EVEN, 32'ha);
		wr(`TBT_CNT_EVEN, 32'h0);
		wr(`TBT_CON_EVEN, 32'h8080);
		cyc(10);
		rd(`TBT_CNT_EVEN, 32'h0);
		glv <= 1'h1;
		cyc(10);
		glv <= 1'h0;
		cyc(4);
		chk("gate flag", irq, 32'h1);
		apb(1'h0, `TBT_CNT_EVEN, 32'h0);
		chk("gated", v >= 32'h9 && v <= 32'hc, 1);
		wr(`TBT_CON_EVEN, 32'h0);
		wr(`TBT_IRQ_STAT, 32'h3);
		$display("clock source done");
		wr(`TBT_PER_ODD, 32'h1);
		for (k = 0; k < 2; k++) begin
			wr(`TBT_CNT_EVEN, 32'hfffe);
			wr(`TBT_CNT_ODD, 32'h0);
			wr(`TBT_CON_EVEN, k ? 32'h8000 : 32'h8008);
			cyc(6);
			wr(`TBT_CON_EVEN, 32'h0);
			rd(`TBT_CNT_ODD, k ? 32'h0 : 32'h1);
		end
		wr(`TBT_CON_ODD, 32'h2000);
		wr(`TBT_CNT_EVEN, 32'h0);
		idle <= 1'h1;
		wr(`TBT_CON_EVEN, 32'h8008);
		cyc(6);
		wr(`TBT_CON_EVEN, 32'h0);
		rd(`TBT_CNT_EVEN, 32'h0);
		idle <= 1'h0;
		$display("pair done");
		wr(`TBT_CON_ODD, 32'h0);
		wr(`TBT_CNT_EVEN, 32'h0);
		wr(`TBT_CON_EVEN, 32'h8000);
		ce <= 1'h0;
		cyc(50);
		ce <= 1'h1;
		wr(`TBT_CON_EVEN, 32'h0);
		rd(`TBT_CNT_EVEN, 32'h2);
		$display("freeze done");
		summarize();
	end
endmodule
`default_nettype wire
